// ===== port_pin_change_detector.sv
// port pin change detector with avalon-mm register slave and interrupt
module port_pin_change_detector
	import pin_change_pkg::*;
#(
	parameter int PIN_COUNT = pin_change_pkg::PIN_COUNT
) (
	input  wire logic                              mclk,
	input  wire logic                              rst_n,
	input  wire logic [PIN_COUNT-1:0]              portPin,
	input  wire logic [pin_change_pkg::ADDR_W-1:0] address,
	input  wire logic                              read,
	input  wire logic                              write,
	input  wire logic [pin_change_pkg::DATA_W-1:0] writedata,
	input  wire logic [3:0]                        byteenable,
	output logic      [pin_change_pkg::DATA_W-1:0] readdata,
	output logic                                   waitrequest,
	output logic                                   portChangeIrq
);
	import pin_change_pkg::*;

	// refuse widths that do not fit the single byte lane
	if (PIN_COUNT < 1 || PIN_COUNT > 8)
	begin : g_bad_width
		$error("PIN_COUNT must lie between 1 and 8");
	end

	typedef struct packed {
		logic [PIN_COUNT-1:0] riseDetectEnable;
		logic [PIN_COUNT-1:0] fallDetectEnable;
		logic [PIN_COUNT-1:0] pinChangeFlag;
		logic [STAT_W-1:0]    irqStatus;
		logic [STAT_W-1:0]    irqMask;
		bus_state_t           busState;
		logic [DATA_W-1:0]    readData;
	} ctl_state_t;

	ctl_state_t           st;
	ctl_state_t           next_st;
	logic [DATA_W-1:0]    readMux;
	logic                 accept;
	logic                 lowLaneWrite;

	pin_event_if #(.W(PIN_COUNT)) pe ();

	// pin synchroniser and edge comparator
	pin_sync #(
		.W     (PIN_COUNT)
	) u_sync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.pinIn (portPin),
		.ev    (pe)
	);

	edge_detect #(
		.W     (PIN_COUNT)
	) u_edge (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ev    (pe)
	);

	// enables steer the comparator
	assign pe.riseEnable = st.riseDetectEnable;
	assign pe.fallEnable = st.fallDetectEnable;

	// request completes in the ack cycle
	assign accept       = (read || write) && (st.busState == BUS_ACK);
	assign waitrequest  = (read || write) && (st.busState != BUS_ACK);
	assign lowLaneWrite = accept && write && byteenable[0];

	// read decode, unmapped reads as zero
	always_comb
	begin
		readMux = '0;
		if (address == RISE_OFS)
			readMux[PIN_COUNT-1:0] = st.riseDetectEnable;
		else if (address == FALL_OFS)
			readMux[PIN_COUNT-1:0] = st.fallDetectEnable;
		else if (address == FLAG_OFS)
			readMux[PIN_COUNT-1:0] = st.pinChangeFlag;
		else if (address == STATUS_OFS)
			readMux[STAT_W-1:0] = st.irqStatus;
		else if (address == MASK_OFS)
			readMux[STAT_W-1:0] = st.irqMask;
		else if (address == LEVEL_OFS)
			readMux[PIN_COUNT-1:0] = pe.level;
	end

	// next state: bus sequencing, writes, read clear, hardware sets
	always_comb
	begin
		next_st = st;
		if (st.busState == BUS_IDLE)
		begin
			if (read || write)
			begin
				next_st.busState = BUS_ACK;
				if (read)
					next_st.readData = readMux;
			end
		end
		else
		begin
			next_st.busState = BUS_IDLE;
		end

		// register writes, low byte lane only
		if (lowLaneWrite)
		begin
			if (address == RISE_OFS)
				next_st.riseDetectEnable = writedata[PIN_COUNT-1:0];
			else if (address == FALL_OFS)
				next_st.fallDetectEnable = writedata[PIN_COUNT-1:0];
			else if (address == FLAG_OFS)
				next_st.pinChangeFlag = writedata[PIN_COUNT-1:0];
			else if (address == MASK_OFS)
				next_st.irqMask = writedata[STAT_W-1:0];
		end

		// clear only the status bits that were actually returned
		if (accept && read && address == STATUS_OFS)
			next_st.irqStatus = st.irqStatus & ~st.readData[STAT_W-1:0];

		// hardware set applied last so it wins over any clear
		next_st.pinChangeFlag = next_st.pinChangeFlag | pe.hit;
		next_st.irqStatus[PORT_IRQ_BIT] = next_st.irqStatus[PORT_IRQ_BIT] | (|pe.hit);
	end

	// state register, all fields zero on reset
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st                  <= '0;
			st.riseDetectEnable <= {PIN_COUNT{RISE_RST_BIT}};
			st.fallDetectEnable <= {PIN_COUNT{FALL_RST_BIT}};
			st.pinChangeFlag    <= {PIN_COUNT{FLAG_RST_BIT}};
			st.irqStatus        <= {STAT_W{STAT_RST_BIT}};
			st.irqMask          <= {STAT_W{MASK_RST_BIT}};
			st.busState         <= BUS_IDLE;
		end
		else
		begin
			st <= next_st;
		end
	end

	// outputs
	assign readdata      = st.readData;
	assign portChangeIrq = |(st.irqStatus & st.irqMask);

	// helper: previous synchronised level and primed marker
	logic [PIN_COUNT-1:0]   lastLevel;
	logic [PRIME_EDGES-1:0] seen;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lastLevel <= '0;
			seen      <= '0;
		end
		else
		begin
			lastLevel <= pe.level;
			seen      <= {seen[PRIME_EDGES-2:0], 1'b1};
		end
	end

	// helper: raw edges seen by this checker, before the enables are applied
	logic [PIN_COUNT-1:0] riseSeen;
	logic [PIN_COUNT-1:0] fallSeen;
	logic                 flagWrite;

	assign riseSeen  = {PIN_COUNT{seen[PRIME_EDGES-1]}} & pe.level & ~lastLevel;
	assign fallSeen  = {PIN_COUNT{seen[PRIME_EDGES-1]}} & ~pe.level & lastLevel;
	assign flagWrite = lowLaneWrite && (address == FLAG_OFS);

	// enabled rising edge sets its flag next cycle
	a_rise_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		|(riseSeen & st.riseDetectEnable)
		|=> ((st.pinChangeFlag & $past(riseSeen & st.riseDetectEnable)) == $past(riseSeen & st.riseDetectEnable)))
		else $error("enabled rising edge did not set its flag");

	// enabled falling edge sets its flag next cycle
	a_fall_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		|(fallSeen & st.fallDetectEnable)
		|=> ((st.pinChangeFlag & $past(fallSeen & st.fallDetectEnable)) == $past(fallSeen & st.fallDetectEnable)))
		else $error("enabled falling edge did not set its flag");

	// a flag rises only from a qualified edge or a software write
	a_no_stray_set: assert property (@(posedge mclk) disable iff (!rst_n)
		!flagWrite
		|=> ((st.pinChangeFlag & ~$past(st.pinChangeFlag)
			& ~$past((riseSeen & st.riseDetectEnable) | (fallSeen & st.fallDetectEnable))) == '0))
		else $error("flag set without an enabled edge");

	// any hit raises the shared status bit, then the irq if unmasked
	a_shared_irq_set: assert property (@(posedge mclk) disable iff (!rst_n)
		(|pe.hit) |=> st.irqStatus[PORT_IRQ_BIT] && (portChangeIrq == st.irqMask[PORT_IRQ_BIT]))
		else $error("shared change flag not raised by an edge");

	// both enables: either direction sets the flag
	a_both_edges: assert property (@(posedge mclk) disable iff (!rst_n)
		|((riseSeen | fallSeen) & st.riseDetectEnable & st.fallDetectEnable)
		|=> (|st.pinChangeFlag) && st.irqStatus[PORT_IRQ_BIT])
		else $error("change in either direction missed with both enables");

	// software write to the flag register stores the value when no edge lands
	a_flag_write_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		flagWrite && (pe.hit == '0)
		|=> st.pinChangeFlag == $past(writedata[PIN_COUNT-1:0]))
		else $error("flag write did not take effect");

	// hardware set beats a simultaneous clear
	a_set_beats_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		flagWrite && (pe.hit != '0)
		|=> ((st.pinChangeFlag & $past(pe.hit)) == $past(pe.hit)))
		else $error("simultaneous clear lost a hardware set");

	// flags hold while nothing writes them
	a_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
		!flagWrite |=> ((st.pinChangeFlag & $past(st.pinChangeFlag)) == $past(st.pinChangeFlag)))
		else $error("flag dropped without a write");

	// rise enable register reads back what was written
	a_enable_readback: assert property (@(posedge mclk) disable iff (!rst_n)
		lowLaneWrite && (address == RISE_OFS)
		|=> st.riseDetectEnable == $past(writedata[PIN_COUNT-1:0]))
		else $error("rise enable write not stored");

	// everything zero while reset is held
	a_reset_values: assert property (@(posedge mclk)
		!rst_n && ($past(rst_n) == 1'b0) |-> (st.riseDetectEnable == '0) && (st.fallDetectEnable == '0)
			&& (st.pinChangeFlag == '0) && !portChangeIrq)
		else $error("registers not zero during reset");

	// every request is answered within one wait cycle
	a_wait_bound: assert property (@(posedge mclk) disable iff (!rst_n)
		(read || write) |-> ##[0:1] !waitrequest)
		else $error("bus request not answered in time");

	// first cycle of a request always waits
	a_first_wait: assert property (@(posedge mclk) disable iff (!rst_n)
		(read || write) && (st.busState == BUS_IDLE)
		|-> waitrequest)
		else $error("request answered without its wait cycle");

	// fall enable stores the written low byte
	a_fall_readback: assert property (@(posedge mclk) disable iff (!rst_n)
		lowLaneWrite && (address == FALL_OFS)
		|=> st.fallDetectEnable == $past(writedata[PIN_COUNT-1:0]))
		else $error("fall enable write not stored");

	// mask stores its written bit
	a_mask_write: assert property (@(posedge mclk) disable iff (!rst_n)
		lowLaneWrite && (address == MASK_OFS)
		|=> st.irqMask == $past(writedata[STAT_W-1:0]))
		else $error("mask write not stored");

	// a write without lane 0 leaves the software registers alone
	a_lane_guard: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && write && !byteenable[0]
		|=> $stable(st.riseDetectEnable) && $stable(st.fallDetectEnable)
			&& $stable(st.irqMask))
		else $error("write without lane 0 changed a register");

	// status ignores writes
	a_status_ro: assert property (@(posedge mclk) disable iff (!rst_n)
		lowLaneWrite && (address == STATUS_OFS) && (pe.hit == '0)
		|=> $stable(st.irqStatus))
		else $error("status changed by a write");

	// a status read clears what it returned unless an edge lands
	a_status_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && read && (address == STATUS_OFS) && (pe.hit == '0)
		|=> (st.irqStatus & $past(st.readData[STAT_W-1:0])) == '0)
		else $error("status read did not clear");

	// read data stands until the next read is captured
	a_read_stable: assert property (@(posedge mclk) disable iff (!rst_n)
		!(read && (st.busState == BUS_IDLE))
		|=> $stable(readdata))
		else $error("read data changed between reads");

	// unused upper read bits stay zero
	a_upper_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		readdata[DATA_W-1:PIN_COUNT] == '0)
		else $error("upper read data bits not zero");

	// a hit needs an armed polarity on its pin
	a_hit_enabled: assert property (@(posedge mclk) disable iff (!rst_n)
		(pe.hit & ~(st.riseDetectEnable | st.fallDetectEnable)) == '0)
		else $error("edge hit on a pin with no enable");

	// no edge in the blind cycles after reset release
	a_reset_blind: assert property (@(posedge mclk)
		$rose(rst_n) |-> (pe.hit == '0) [*3])
		else $error("false edge right after reset");

endmodule : port_pin_change_detector

// ===== pin_change_pkg.sv
// constants, types and register map of the port pin change detector
// Operation
// - Each of the eight pins has a rising-edge enable bit that arms detection of a low-to-high change on that pin.
// - Each of the eight pins has a falling-edge enable bit that arms detection of a high-to-low change on that pin.
// - A cleared edge enable bit makes changes of that polarity on its pin set no flag at all.
// - A pin's change flag sets on a rising edge with its rise enable set, or a falling edge with its fall enable set.
// - Every enabled edge also sets the shared port change interrupt flag along with the pin's own flag.
// - Both edge enable registers are readable and writable and reset to zero on every reset.
// - The change flag bits are readable, writable and set by hardware, and reset to zero on every reset.
package pin_change_pkg;

	// geometry of the port and the bus
	localparam int PIN_COUNT = 8;
	localparam int DATA_W    = 32;
	localparam int ADDR_W    = 5;

	// register byte offsets
	localparam logic [ADDR_W-1:0] RISE_OFS   = 5'h00;
	localparam logic [ADDR_W-1:0] FALL_OFS   = 5'h04;
	localparam logic [ADDR_W-1:0] FLAG_OFS   = 5'h08;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h0c;
	localparam logic [ADDR_W-1:0] MASK_OFS   = 5'h10;
	localparam logic [ADDR_W-1:0] LEVEL_OFS  = 5'h14;

	// interrupt status layout
	localparam int STAT_W       = 1;
	localparam int PORT_IRQ_BIT = 0;

	// reset values, one bit replicated over the field
	localparam logic RISE_RST_BIT = 1'b0;
	localparam logic FALL_RST_BIT = 1'b0;
	localparam logic FLAG_RST_BIT = 1'b0;
	localparam logic STAT_RST_BIT = 1'b0;
	localparam logic MASK_RST_BIT = 1'b0;

	// edges after reset release before the edge compare trusts its last sample
	localparam int PRIME_EDGES = 3;

	// bus answer sequencing
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} bus_state_t;

endpackage : pin_change_pkg

// ===== pin_event_if.sv
// carrier between synchroniser, edge detector and register logic
interface pin_event_if #(
	parameter int W = 8
);
	logic [W-1:0] level;
	logic [W-1:0] riseEnable;
	logic [W-1:0] fallEnable;
	logic [W-1:0] hit;

	modport sync (output level);
	modport det  (input level, input riseEnable, input fallEnable, output hit);
	modport ctl  (input level, input hit, output riseEnable, output fallEnable);
endinterface : pin_event_if

// ===== pin_sync.sv
// two-flop synchroniser for the port pins
module pin_sync #(
	parameter int W = 8
) (
	input wire logic         mclk,
	input wire logic         rst_n,
	input wire logic [W-1:0] pinIn,
	pin_event_if.sync        ev
);
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	// first stage feeds only the second
	always_comb
	begin
		next_st.stage1 = pinIn;
		next_st.stage2 = st.stage1;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign ev.level = st.stage2;
endmodule : pin_sync

// ===== edge_detect.sv
// per-pin edge comparison against the previous synchronised sample
module edge_detect #(
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	pin_event_if.det ev
);
	typedef struct packed {
		logic [W-1:0]                           prev;
		logic [pin_change_pkg::PRIME_EDGES-1:0] fill;
	} edge_state_t;

	edge_state_t st;
	edge_state_t next_st;

	// remember last level; fill chain keeps the compare blind until prev holds a synchronised sample
	always_comb
	begin
		next_st.prev = ev.level;
		next_st.fill = {st.fill[pin_change_pkg::PRIME_EDGES-2:0], 1'b1};
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	// qualified edges, disabled polarities dropped
	assign ev.hit = {W{st.fill[pin_change_pkg::PRIME_EDGES-1]}}
		& ((ev.riseEnable & ev.level & ~st.prev)
		| (ev.fallEnable & ~ev.level & st.prev));
endmodule : edge_detect

// ===== pin_source.sv
// outside-world model driving the monitored port pins
module pin_source #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic [W-1:0] level,
	output logic      [W-1:0] portPin
);
	timeunit 1ns;
	timeprecision 1ps;

	// pins change just after a clock edge, like any board signal
	always_ff @(posedge mclk)
	begin
		portPin <= level;
	end
endmodule : pin_source

// ===== tb_top.sv
// self-checking bench for the port pin change detector
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin nErrors++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pin_change_pkg::*;
	logic              mclk;
	logic              rst_n;
	logic [7:0]        level;
	logic [7:0]        portPin;
	logic [ADDR_W-1:0] address;
	logic              read;
	logic              write;
	logic [DATA_W-1:0] writedata;
	logic [3:0]        byteenable;
	logic [DATA_W-1:0] readdata;
	logic              waitrequest;
	logic              portChangeIrq;
	int                nErrors;
	int                testsRun;
	int                cycles;

	pin_source #(.W(8)) pins (.mclk(mclk), .level(level), .portPin(portPin));

	port_pin_change_detector #(.PIN_COUNT(8)) dut (
		.mclk(mclk), .rst_n(rst_n), .portPin(portPin), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .portChangeIrq(portChangeIrq)
	);

	// free-running system clock
	always #2.5 mclk = ~mclk;

	// one avalon transfer, held until waitrequest is seen low
	task automatic busOp(input logic isWr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [DATA_W-1:0] q);
		@(posedge mclk);
		address <= a;
		read <= !isWr;
		write <= isWr;
		writedata <= {24'h0, d};
		byteenable <= be;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : busOp

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
		logic [DATA_W-1:0] q;
		busOp(1'b1, a, d, be, q);
	endtask : wr

	task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] q;
		busOp(1'b0, a, 8'h00, 4'h1, q);
		`CHK(q, exp)
	endtask : rdChk

	// new pin levels, then enough edges for sync and flag set
	task automatic setPins(input logic [7:0] v);
		@(posedge mclk);
		level <= v;
		repeat (6) @(posedge mclk);
	endtask : setPins

	task automatic results();
		$display("comparisons %0d mismatches %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	// hang guard
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			nErrors++;
			results();
		end
	end

	// main sequence
	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		level = 8'h00;
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		byteenable = 4'h0;
		nErrors = 0;
		testsRun = 0;
		cycles = 0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		rdChk(RISE_OFS, 32'h0);
		rdChk(FALL_OFS, 32'h0);
		rdChk(FLAG_OFS, 32'h0);
		rdChk(STATUS_OFS, 32'h0);
		rdChk(MASK_OFS, 32'h0);
		`CHK(portChangeIrq, 1'b0)
		wr(RISE_OFS, 8'ha5);
		rdChk(RISE_OFS, 32'ha5);
		wr(FALL_OFS, 8'h5a);
		rdChk(FALL_OFS, 32'h5a);
		wr(RISE_OFS, 8'hff, 4'h0);
		rdChk(RISE_OFS, 32'ha5);
		rdChk(5'h18, 32'h0);
		// edges with both enables off
		wr(RISE_OFS, 8'h00);
		wr(FALL_OFS, 8'h00);
		setPins(8'hff);
		setPins(8'h00);
		rdChk(FLAG_OFS, 32'h0);
		rdChk(STATUS_OFS, 32'h0);
		// split enables, interrupt unmasked
		wr(MASK_OFS, 8'h01);
		rdChk(MASK_OFS, 32'h1);
		wr(RISE_OFS, 8'h0f);
		wr(FALL_OFS, 8'hf0);
		setPins(8'hff);
		rdChk(FLAG_OFS, 32'h0f);
		`CHK(portChangeIrq, 1'b1)
		rdChk(STATUS_OFS, 32'h1);
		@(posedge mclk);
		`CHK(portChangeIrq, 1'b0)
		rdChk(STATUS_OFS, 32'h0);
		wr(FLAG_OFS, 8'h00);
		rdChk(FLAG_OFS, 32'h0);
		setPins(8'h00);
		rdChk(FLAG_OFS, 32'hf0);
		wr(FLAG_OFS, 8'h30);
		rdChk(FLAG_OFS, 32'h30);
		rdChk(STATUS_OFS, 32'h1);
		// masked event keeps the line low
		wr(MASK_OFS, 8'h00);
		setPins(8'hff);
		`CHK(portChangeIrq, 1'b0)
		rdChk(STATUS_OFS, 32'h1);
		// both directions on one pin
		wr(FLAG_OFS, 8'h00);
		wr(RISE_OFS, 8'h01);
		wr(FALL_OFS, 8'h01);
		setPins(8'hfe);
		rdChk(FLAG_OFS, 32'h01);
		wr(FLAG_OFS, 8'h00);
		setPins(8'hff);
		rdChk(FLAG_OFS, 32'h01);
		wr(FLAG_OFS, 8'h81);
		rdChk(FLAG_OFS, 32'h81);
		// level register follows the pins and ignores writes
		rdChk(LEVEL_OFS, 32'hff);
		wr(LEVEL_OFS, 8'h00);
		rdChk(LEVEL_OFS, 32'hff);
		// reset in mid-run with pins already high: not an edge
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		wr(RISE_OFS, 8'hff);
		rdChk(FALL_OFS, 32'h0);
		rdChk(FLAG_OFS, 32'h0);
		rdChk(STATUS_OFS, 32'h0);
		rdChk(RISE_OFS, 32'hff);
		results();
	end
endmodule : tb_top
